// ---- verilog/port_six_consts.vh ----
// Contract
// - The port has seven two-way pins, 0 to 6, each general I/O or a bus control function.
// - With area 3 set for DRAM, pins 6, 5 and 4 carry the DRAM write or column strobes instead.
// - In expanded modes 1 to 6, pins 6 to 3 drive low write, high write, read and address strobes.
// - In expanded modes, pins 2 to 0 without alternate function follow their direction bits.
// - In single-chip mode 7 every pin is general I/O under its direction bit.
// - The direction register is write-only, reads all ones, and bit 7 is reserved.
// - Reset and hardware standby load direction with 0x80; software standby keeps it.
// - In software standby a pin whose direction bit is 1 keeps driving its output.
// - A data read gives the pin level where direction is 0 and the stored bit where it is 1.
// - Data bit 7 is reserved, ignores writes and reads as one.
// - Reset and hardware standby load data with 0x80; software standby keeps it.
// - In expanded modes pin 3 is the address strobe whatever its direction bit.
// - In expanded modes, pin 0 is general I/O only with wait-disable bits all ones and wait select high 0.
`ifndef PORT_SIX_CONSTS_VH
`define PORT_SIX_CONSTS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define ADDR_W          16
`define DIR_ADDR        16'hFFC9
`define DATA_ADDR       16'hFFCB
`define REG_RESET       8'h80
`define READ_ALL_ONES   8'hFF
`define RSVD_MASK       8'h80
`define WAIT_EN_ALL     8'hFF

// ----------------------------------------------------------------
// Pin positions
// ----------------------------------------------------------------
`define PIN_N           7
`define PIN_LWR         6
`define PIN_HWR         5
`define PIN_RD          4
`define PIN_ADS         3
`define PIN_ACK         2
`define PIN_REQ         1
`define PIN_WAIT        0
`define MODE_SINGLE     3'h7

`endif

// ---- verilog/port_six_regs.v ----
`timescale 1ns/1ps
`include "port_six_consts.vh"

module port_six_regs (
	input  wire                 clk_in,
	input  wire                 rstn_in,
	input  wire                 ce_in,
	input  wire                 hw_standby_in,
	input  wire [`ADDR_W-1:0]   addr_in,
	input  wire [7:0]           wdata_in,
	input  wire                 wr_in,
	output reg  [7:0]           dir_r,
	output reg  [7:0]           dat_r
);

	// ----------------------------------------------------------------
	// Direction and output-value storage
	// ----------------------------------------------------------------
	// Software standby simply does not touch these registers
	always @(posedge clk_in) begin
		if (!rstn_in || hw_standby_in) begin
			dir_r <= `REG_RESET;
			dat_r <= `REG_RESET;
		end else if (ce_in && wr_in) begin
			if (addr_in == `DIR_ADDR) begin
				dir_r <= wdata_in | `RSVD_MASK;
			end else if (addr_in == `DATA_ADDR) begin
				dat_r <= wdata_in | `RSVD_MASK;
			end
		end
	end

endmodule

// ---- verilog/port_six_pinmux.v ----
`timescale 1ns/1ps
`include "port_six_consts.vh"

module port_six_pinmux (
	input  wire [2:0]           mode_in,
	input  wire                 dram_area3_in,
	input  wire                 bus_release_enable_bit_in,
	input  wire [7:0]           wait_disable_bits_in,
	input  wire                 wait_mode_select_high_in,
	input  wire [7:0]           dir_in,
	input  wire [7:0]           dat_in,
	input  wire                 low_byte_write_strobe_in,
	input  wire                 high_byte_write_strobe_in,
	input  wire                 read_strobe_in,
	input  wire                 address_strobe_in,
	input  wire                 dram_lower_write_in,
	input  wire                 dram_upper_write_in,
	input  wire                 dram_read_strobe_in,
	input  wire                 bus_release_ack_in,
	output reg  [6:0]           pin_o_nxt,
	output reg  [6:0]           pin_oe_nxt,
	output reg                  req_sel_nxt,
	output reg                  wait_sel_nxt
);

	wire expanded;
	assign expanded = (mode_in != `MODE_SINGLE);

	// ----------------------------------------------------------------
	// Per-pin function selection
	// ----------------------------------------------------------------
	// General I/O default under direction bits, then alternate overrides
	always @* begin
		pin_o_nxt    = dat_in[6:0];
		pin_oe_nxt   = dir_in[6:0];
		req_sel_nxt  = 1'b0;
		wait_sel_nxt = 1'b0;
		if (expanded) begin
			pin_oe_nxt[`PIN_LWR] = 1'b1;
			pin_oe_nxt[`PIN_HWR] = 1'b1;
			pin_oe_nxt[`PIN_RD]  = 1'b1;
			pin_oe_nxt[`PIN_ADS] = 1'b1;
			pin_o_nxt[`PIN_ADS]  = address_strobe_in;
			if (dram_area3_in) begin
				pin_o_nxt[`PIN_LWR] = dram_lower_write_in;
				pin_o_nxt[`PIN_HWR] = dram_upper_write_in;
				pin_o_nxt[`PIN_RD]  = dram_read_strobe_in;
			end else begin
				pin_o_nxt[`PIN_LWR] = low_byte_write_strobe_in;
				pin_o_nxt[`PIN_HWR] = high_byte_write_strobe_in;
				pin_o_nxt[`PIN_RD]  = read_strobe_in;
			end
			if (bus_release_enable_bit_in) begin
				pin_oe_nxt[`PIN_ACK] = 1'b1;
				pin_o_nxt[`PIN_ACK]  = bus_release_ack_in;
				pin_oe_nxt[`PIN_REQ] = 1'b0;
				req_sel_nxt          = 1'b1;
			end
			if (wait_disable_bits_in != `WAIT_EN_ALL || wait_mode_select_high_in) begin
				pin_oe_nxt[`PIN_WAIT] = 1'b0;
				wait_sel_nxt          = 1'b1;
			end
		end
	end

endmodule

// ---- verilog/port_six_bus_control_gpio.v ----
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
`include "port_six_consts.vh"

module port_six_bus_control_gpio (
	input  wire                 clk_in,
	input  wire                 rstn_in,
	input  wire                 ce_in,
	input  wire                 hw_standby_in,
	input  wire [`ADDR_W-1:0]   addr_in,
	input  wire [7:0]           wdata_in,
	input  wire                 wr_in,
	input  wire                 rd_in,
	output reg  [7:0]           rdata_out,
	input  wire [2:0]           mode_in,
	input  wire                 dram_area3_in,
	input  wire                 bus_release_enable_bit_in,
	input  wire [7:0]           wait_disable_bits_in,
	input  wire                 wait_mode_select_high_in,
	input  wire                 low_byte_write_strobe_in,
	input  wire                 high_byte_write_strobe_in,
	input  wire                 read_strobe_in,
	input  wire                 address_strobe_in,
	input  wire                 dram_lower_write_in,
	input  wire                 dram_upper_write_in,
	input  wire                 dram_read_strobe_in,
	input  wire                 bus_release_ack_in,
	input  wire [6:0]           pin_in,
	output reg  [6:0]           pin_out,
	output reg  [6:0]           pin_oe_out,
	output reg                  bus_release_request_out,
	output reg                  wait_request_out
);

	wire [7:0] dir_r;
	wire [7:0] dat_r;
	wire [6:0] pin_o_nxt;
	wire [6:0] pin_oe_nxt;
	wire       req_sel_nxt;
	wire       wait_sel_nxt;
	reg  [7:0] rdata_nxt;

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	// Direction and output value, reset and hardware-standby loaded
	port_six_regs u_regs (
		.clk_in        (clk_in),
		.rstn_in       (rstn_in),
		.ce_in         (ce_in),
		.hw_standby_in (hw_standby_in),
		.addr_in       (addr_in),
		.wdata_in      (wdata_in),
		.wr_in         (wr_in),
		.dir_r         (dir_r),
		.dat_r         (dat_r)
	);

	// ----------------------------------------------------------------
	// Pin function mux
	// ----------------------------------------------------------------
	// Seven pins, each general I/O or a bus control function
	port_six_pinmux u_mux (
		.mode_in                   (mode_in),
		.dram_area3_in             (dram_area3_in),
		.bus_release_enable_bit_in (bus_release_enable_bit_in),
		.wait_disable_bits_in      (wait_disable_bits_in),
		.wait_mode_select_high_in  (wait_mode_select_high_in),
		.dir_in                    (dir_r),
		.dat_in                    (dat_r),
		.low_byte_write_strobe_in  (low_byte_write_strobe_in),
		.high_byte_write_strobe_in (high_byte_write_strobe_in),
		.read_strobe_in            (read_strobe_in),
		.address_strobe_in         (address_strobe_in),
		.dram_lower_write_in       (dram_lower_write_in),
		.dram_upper_write_in       (dram_upper_write_in),
		.dram_read_strobe_in       (dram_read_strobe_in),
		.bus_release_ack_in        (bus_release_ack_in),
		.pin_o_nxt                 (pin_o_nxt),
		.pin_oe_nxt                (pin_oe_nxt),
		.req_sel_nxt               (req_sel_nxt),
		.wait_sel_nxt              (wait_sel_nxt)
	);

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Direction reads all ones; data mixes pin level and stored bits
	always @* begin
		rdata_nxt = 8'h00;
		if (rd_in && addr_in == `DIR_ADDR) begin
			rdata_nxt = `READ_ALL_ONES;
		end else if (rd_in && addr_in == `DATA_ADDR) begin
			rdata_nxt = {1'b1, (pin_in & ~dir_r[6:0]) | (dat_r[6:0] & dir_r[6:0])};
		end
	end

	// ----------------------------------------------------------------
	// Output flops
	// ----------------------------------------------------------------
	// Pins follow register writes one edge after the write
	always @(posedge clk_in) begin
		if (!rstn_in) begin
			rdata_out               <= 8'h00;
			pin_out                 <= 7'h00;
			pin_oe_out              <= 7'h00;
			bus_release_request_out <= 1'b0;
			wait_request_out        <= 1'b0;
		end else if (ce_in) begin
			rdata_out               <= rdata_nxt;
			pin_out                 <= pin_o_nxt;
			pin_oe_out              <= pin_oe_nxt;
			bus_release_request_out <= req_sel_nxt & pin_in[`PIN_REQ];
			wait_request_out        <= wait_sel_nxt & pin_in[`PIN_WAIT];
		end
	end

endmodule

// ---- sim/port_six_checker.sv ----
`timescale 1ns/1ps
module port_six_checker (
	input wire		clk_in,
	input wire		rstn_in,
	input wire		ce_in,
	input wire [15:0]	addr_in,
	input wire		rd_in,
	input wire [7:0]	rdata_out,
	input wire [2:0]	mode_in,
	input wire		dram_area3_in,
	input wire		bus_release_enable_bit_in,
	input wire [7:0]	wait_disable_bits_in,
	input wire		wait_mode_select_high_in,
	input wire		address_strobe_in,
	input wire		dram_lower_write_in,
	input wire		dram_upper_write_in,
	input wire		dram_read_strobe_in,
	input wire		bus_release_ack_in,
	input wire [6:0]	pin_in,
	input wire [6:0]	pin_out,
	input wire [6:0]	pin_oe_out,
	input wire		bus_release_request_out,
	input wire		wait_request_out
);
	// All checks sample on the port clock and rest during reset
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// Register reads
	dir_read_ones_a: assert property (ce_in && rd_in && addr_in == 16'hFFC9 |=> rdata_out == 8'hFF)
		else $error("direction read not all ones");
	data_top_one_a: assert property (ce_in && rd_in && addr_in == 16'hFFCB |=> rdata_out[7])
		else $error("data bit 7 read as zero");
	// Expanded mode strobe pins
	strobe_drive_a: assert property (ce_in && mode_in != 3'h7 |=> pin_oe_out[6:3] == 4'hF)
		else $error("strobe pins not driven");
	as_follow_a: assert property (ce_in && mode_in != 3'h7 |=> pin_out[3] == $past(address_strobe_in))
		else $error("address strobe pin wrong");
	dram_strobe_a: assert property (ce_in && mode_in != 3'h7 && dram_area3_in |=>
		pin_out[6:4] == {$past(dram_lower_write_in), $past(dram_upper_write_in),
		$past(dram_read_strobe_in)}) else $error("dram strobes wrong");
	// Release and wait pins
	release_pins_a: assert property (ce_in && mode_in != 3'h7 && bus_release_enable_bit_in |=>
		pin_oe_out[2:1] == 2'h2 && pin_out[2] == $past(bus_release_ack_in)
		&& bus_release_request_out == $past(pin_in[1])) else $error("release pins wrong");
	wait_pin_a: assert property (ce_in && mode_in != 3'h7
		&& (wait_disable_bits_in != 8'hFF || wait_mode_select_high_in) |=>
		!pin_oe_out[0] && wait_request_out == $past(pin_in[0])) else $error("wait pin wrong");
	wait_gpio_a: assert property (ce_in && wait_disable_bits_in == 8'hFF
		&& !wait_mode_select_high_in |=> !wait_request_out) else $error("wait input while gpio");
	single_chip_a: assert property (ce_in && mode_in == 3'h7 |=> !bus_release_request_out
		&& !wait_request_out) else $error("request active in single chip");
endmodule

// ---- sim/pin_far_model.sv ----
`timescale 1ns/1ps
module pin_far_model (
	input wire [6:0]	pin_out,
	input wire [6:0]	pin_oe_out,
	input wire [6:0]	ext_in,
	output wire [6:0]	pin_in
);
	// Wire level: port drive where enabled, far device level elsewhere
	assign pin_in = (pin_out & pin_oe_out) | (ext_in & ~pin_oe_out);
endmodule

// ---- sim/tb_port_six_bus_control_gpio.sv ----
`timescale 1ns/1ps
module tb_port_six_bus_control_gpio;
	reg		clk_in = 1'b0, rstn_in = 1'b0, ce_in = 1'b1, hw_standby_in = 1'b0;
	reg		wr_in = 1'b0, rd_in = 1'b0, dram_area3_in = 1'b0;
	reg		bus_release_enable_bit_in = 1'b0, wait_mode_select_high_in = 1'b0;
	reg		low_byte_write_strobe_in = 1'b1, high_byte_write_strobe_in = 1'b0;
	reg		read_strobe_in = 1'b1, address_strobe_in = 1'b0, dram_lower_write_in = 1'b0;
	reg		dram_upper_write_in = 1'b1, dram_read_strobe_in = 1'b1, bus_release_ack_in = 1'b1;
	reg [15:0]	addr_in = 16'h0000;
	reg [7:0]	wdata_in = 8'h00, wait_disable_bits_in = 8'hFF, rd_v;
	reg [2:0]	mode_in = 3'h7;
	reg [6:0]	ext_in = 7'h2A;
	wire [7:0]	rdata_out;
	wire [6:0]	pin_in, pin_out, pin_oe_out;
	wire		bus_release_request_out, wait_request_out;
	integer		err_total = 0, cmp_count = 0, cyc = 0, m;
	always #20 clk_in = ~clk_in;
	port_six_bus_control_gpio port_six_bus_control_gpio_i (.*);
	pin_far_model pin_far_model_i (.*);
	// Verdict and end of run
	task stop_test; begin
		$display("mismatches %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	end endtask
	// Hang guard
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_total = err_total + 1;
			stop_test;
		end
	end
	task chk(input string nm, input [7:0] e, input [7:0] g); begin
		cmp_count = cmp_count + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	end endtask
	// Register bus cycles
	task wr(input [15:0] a, input [7:0] d); begin
		@(posedge clk_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
		@(posedge clk_in) wr_in <= 1'b0;
	end endtask
	task rdr(input [15:0] a); begin
		@(posedge clk_in) {addr_in, rd_in} <= {a, 1'b1};
		@(posedge clk_in) rd_in <= 1'b0;
		#1 rd_v = rdata_out;
	end endtask
	task t_regs; begin
		rdr(16'hFFC9); chk("dir read", 8'hFF, rd_v);
		rdr(16'hFFCB); chk("data pins", {1'b1, ext_in}, rd_v);
		wr(16'hFFC9, 8'h7F); rdr(16'hFFCB); chk("data reset", 8'h80, rd_v);
		rdr(16'hFFCA); chk("unmapped", 8'h00, rd_v);
	end endtask
	task t_gpio; begin
		wr(16'hFFC9, 8'h0F); wr(16'hFFCB, 8'h35);
		@(posedge clk_in) #1 chk("gpio oe", 8'h0F, {1'b0, pin_oe_out});
		chk("gpio out", 8'h05, {1'b0, pin_out & 7'h0F});
		rdr(16'hFFCB); chk("mixed", {1'b1, ext_in & 7'h70 | 7'h05}, rd_v);
	end endtask
	task t_standby; begin
		@(posedge clk_in) hw_standby_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		hw_standby_in <= 1'b0;
		@(posedge clk_in) #1 chk("stby oe", 8'h00, {1'b0, pin_oe_out});
		wr(16'hFFC9, 8'h7F); rdr(16'hFFCB); chk("stby data", 8'h80, rd_v);
	end endtask
	// Clock enable low freezes registers and pins
	task t_freeze; begin
		@(posedge clk_in) ce_in <= 1'b0;
		wr(16'hFFCB, 8'h7F);
		@(posedge clk_in) #1 chk("frozen pins", 8'h00, {1'b0, pin_out});
		@(posedge clk_in) ce_in <= 1'b1;
		rdr(16'hFFCB); chk("frozen data", 8'h80, rd_v);
	end endtask
	task t_exp; begin
		wr(16'hFFC9, 8'h06);
		for (m = 1; m < 7; m = m + 1) begin
			@(posedge clk_in) {mode_in, bus_release_enable_bit_in, dram_area3_in} <= {m[2:0], 2'b00};
			wait_disable_bits_in <= 8'hFF;
			ext_in <= ext_in ^ 7'h03;
			address_strobe_in <= m[0];
			@(posedge clk_in) #1 chk("exp oe", 8'h7E, {1'b0, pin_oe_out});
			chk("exp strobes", {4'h5, m[0], 3'h0}, {1'b0, pin_out & 7'h78});
			@(posedge clk_in) {bus_release_enable_bit_in, dram_area3_in} <= 2'b11;
			wait_disable_bits_in <= 8'hFE;
			@(posedge clk_in) #1 chk("rel oe", 8'h7C, {1'b0, pin_oe_out});
			chk("rel pins", 8'h34, {1'b0, pin_out & 7'h74});
			// Pin 1 is driven until the enable update lands, so wait one more edge
			@(posedge clk_in) #1 chk("requests", {6'h00, ext_in[1:0]},
				{6'h00, bus_release_request_out, wait_request_out});
		end
		// Wait select high alone hands pin 0 to the wait input
		@(posedge clk_in) {wait_disable_bits_in, wait_mode_select_high_in} <= {8'hFF, 1'b1};
		ext_in <= 7'h01;
		@(posedge clk_in) #1 chk("wait select", 8'h01, {7'h00, wait_request_out});
		@(posedge clk_in) wait_mode_select_high_in <= 1'b0;
		@(posedge clk_in) #1 chk("wait gpio", 8'h00, {7'h00, wait_request_out});
	end endtask
	// Main sequence
	initial begin
		repeat (10) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_regs;
		t_gpio;
		t_standby;
		t_freeze;
		t_exp;
		stop_test;
	end
endmodule
bind port_six_bus_control_gpio port_six_checker port_six_checker_i (.*);
